// ==== core/lam_heartbeat.sv ====
// Free-running heartbeat interval timer
`timescale 1ns/1ps
`default_nettype none
module lam_heartbeat
    import lam_pkg::*;
#(
    parameter logic [31:0] INTERVAL = HEARTBEAT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    logic [31:0] count_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h0;
            tick <= 1'b0;
        end else if (count_reg >= INTERVAL - 32'h1) begin
            count_reg <= 32'h0;
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule // lam_heartbeat
`default_nettype wire

// ==== core/lam_pkg.sv ====
// Shared constants and types for the network-alert message builder
package lam_pkg;

    localparam int MSG_BITS = 36;
    localparam int SEQ_BITS = 4;
    localparam int BYTE_BITS = 8;

    // Heartbeat interval, chosen inside the 30 to 32 s window
    localparam longint HEARTBEAT_MS = 31000;
    localparam longint CLK_PERIOD_PS = 8000;
    localparam longint HEARTBEAT_CYCLES_L = (HEARTBEAT_MS * 64'd1000000000) / CLK_PERIOD_PS;
    localparam logic [31:0] HEARTBEAT_CYCLES = HEARTBEAT_CYCLES_L[31:0];

    localparam logic [SEQ_BITS-1:0] SEQ_RESET = 4'h0;

    // Sleep type codes: S1 to S4 map to the sleeping state, S5 to soft off
    localparam logic [2:0] SLP_TYPE_S0 = 3'h0;
    localparam logic [2:0] SLP_TYPE_S1 = 3'h1;
    localparam logic [2:0] SLP_TYPE_S4 = 3'h4;
    localparam logic [2:0] SLP_TYPE_S5 = 3'h5;

    typedef enum logic [1:0] {
        LAM_PWR_G0 = 2'b00,
        LAM_PWR_G1 = 2'b01,
        LAM_PWR_G2 = 2'b10,
        LAM_PWR_PREBOOT = 2'b11
    } lam_pwr_t;

    localparam lam_pwr_t PWR_RESET = LAM_PWR_G2;

    // Message in transmit order, first member is sent first
    typedef struct packed {
        logic coverTamper;
        logic tempEvent;
        logic procMissing;
        logic timerEvent;
        logic softwareEvent;
        logic gpioStatus;
        logic [SEQ_BITS-1:0] msgSequence;
        lam_pwr_t powerState;
        logic [BYTE_BITS-1:0] userMessageA;
        logic [BYTE_BITS-1:0] userMessageB;
        logic [BYTE_BITS-1:0] watchdogStatusByte;
    } lam_msg_t;

endpackage

// ==== core/lam_serializer.sv ====
// Shifts one alert message out MSB first on the sampled link clock, then checks the acknowledge
`timescale 1ns/1ps
`default_nettype none
module lam_serializer
    import lam_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire lam_msg_t frame,
    input wire logic linkFall,
    input wire logic linkRise,
    input wire logic dataLevel,
    output logic busy,
    output logic dataOe,
    output logic ackPulse,
    output logic nackPulse
);
    logic [MSG_BITS-1:0] shift_reg;
    logic [5:0] bitCount_reg;
    logic ackSlot_reg;

    // Data changes only while the link clock is low; open drain, so a one is a release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
            bitCount_reg <= 6'h0;
            ackSlot_reg <= 1'b0;
            busy <= 1'b0;
            dataOe <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                shift_reg <= frame;
                bitCount_reg <= 6'h0;
                ackSlot_reg <= 1'b0;
                busy <= 1'b1;
            end
        end else if (linkFall) begin
            if (bitCount_reg < 6'(MSG_BITS)) begin
                dataOe <= !shift_reg[MSG_BITS-1];
                shift_reg <= {shift_reg[MSG_BITS-2:0], 1'b0};
                bitCount_reg <= bitCount_reg + 6'h1;
            end else begin
                dataOe <= 1'b0;
                ackSlot_reg <= 1'b1;
            end
        end else if (linkRise && ackSlot_reg) begin
            busy <= 1'b0;
            ackSlot_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ackPulse <= 1'b0;
            nackPulse <= 1'b0;
        end else begin
            ackPulse <= busy && linkRise && ackSlot_reg && !dataLevel;
            nackPulse <= busy && linkRise && ackSlot_reg && dataLevel;
        end
    end
endmodule // lam_serializer
`default_nettype wire

// ==== core/lan_alert_message_builder.sv ====
// Network-alert message builder: status capture, power state, sequencing and send control
//
// Behaviour
// - Cover tamper bit follows intrusion latch.
// - Temperature bit set while overtemp asserted.
// - Processor missing when inhibit, double timeout, boot fail.
// - Without inhibit, double timeout requests reboot.
// - Double timeout survives reboot; boot fail follows.
// - After reboot attempt, next expiry flags processor missing.
// - Timer bit set on watchdog expiry.
// - Software bit set by send-immediately write.
// - GPIO bit is inverse of watched line.
// - Any watched line transition sends event.
// - Four-bit sequence from zero, wraps, per event.
// - Multi-bit fields sent most significant first.
// - User messages and watchdog byte copied MSB first.
// - Pre-boot entered leaving G1/G2; exits reset/override.
// - G0 on CPU reset release; leaves on sleep/override.
// - G1 on sleep S1-S4; leaves on wake/override.
// - G2 on sleep S5 or override; leaves on wake.
// - Heartbeat every thirty to thirty-two seconds.
// - Heartbeats do not advance the sequence.
// - Controller acknowledges; device checks acknowledge.
`timescale 1ns/1ps
`default_nettype none
module lan_alert_message_builder
    import lam_pkg::*;
#(
    parameter logic [31:0] HEARTBEAT_INTERVAL = HEARTBEAT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic intrusionLatched,
    input wire logic overtempInputN,
    input wire logic rebootInhibit,
    input wire logic doubleTimeoutFlag,
    input wire logic bootFailFlag,
    input wire logic mgmtWatchdogExpire,
    input wire logic sendImmediately,
    input wire logic watchedGpioLine,
    input wire logic [BYTE_BITS-1:0] userMessageA,
    input wire logic [BYTE_BITS-1:0] userMessageB,
    input wire logic [BYTE_BITS-1:0] watchdogStatusByte,
    input wire logic sleepS3OutN,
    input wire logic cpuResetN,
    input wire logic sleepEnable,
    input wire logic [2:0] sleepType,
    input wire logic powerButtonOverride,
    input wire logic alertClkIn,
    input wire logic alertDataIn,
    output logic alertDataOut,
    output logic alertDataOe,
    output logic rebootRequest,
    output logic [SEQ_BITS-1:0] msgSequence,
    output lam_pwr_t powerState,
    output logic msgBusy,
    output logic msgAcked,
    output logic msgNacked
);
    // Pin synchronisers; stage one is read only by stage two
    logic overtempMeta_reg, overtempSync_reg;
    logic gpioMeta_reg, gpioSync_reg, gpioLast_reg;
    logic s3Meta_reg, s3Sync_reg, s3Last_reg;
    logic cpuRstMeta_reg, cpuRstSync_reg, cpuRstLast_reg;
    logic clkMeta_reg, clkSync_reg, clkLast_reg;
    logic dataMeta_reg, dataSync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtempMeta_reg <= 1'b1;
            overtempSync_reg <= 1'b1;
            gpioMeta_reg <= 1'b1;
            gpioSync_reg <= 1'b1;
            s3Meta_reg <= 1'b0;
            s3Sync_reg <= 1'b0;
            cpuRstMeta_reg <= 1'b0;
            cpuRstSync_reg <= 1'b0;
            clkMeta_reg <= 1'b1;
            clkSync_reg <= 1'b1;
            dataMeta_reg <= 1'b1;
            dataSync_reg <= 1'b1;
        end else begin
            overtempMeta_reg <= overtempInputN;
            overtempSync_reg <= overtempMeta_reg;
            gpioMeta_reg <= watchedGpioLine;
            gpioSync_reg <= gpioMeta_reg;
            s3Meta_reg <= sleepS3OutN;
            s3Sync_reg <= s3Meta_reg;
            cpuRstMeta_reg <= cpuResetN;
            cpuRstSync_reg <= cpuRstMeta_reg;
            clkMeta_reg <= alertClkIn;
            clkSync_reg <= clkMeta_reg;
            dataMeta_reg <= alertDataIn;
            dataSync_reg <= dataMeta_reg;
        end
    end

    // Previous-value registers start at the synchroniser reset values, so release shows no edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gpioLast_reg <= 1'b1;
            s3Last_reg <= 1'b0;
            cpuRstLast_reg <= 1'b0;
            clkLast_reg <= 1'b1;
        end else begin
            gpioLast_reg <= gpioSync_reg;
            s3Last_reg <= s3Sync_reg;
            cpuRstLast_reg <= cpuRstSync_reg;
            clkLast_reg <= clkSync_reg;
        end
    end

    logic gpioToggle;
    logic s3Deassert;
    logic cpuRstRelease;
    logic linkFall;
    logic linkRise;
    assign gpioToggle = gpioSync_reg != gpioLast_reg;
    assign s3Deassert = s3Sync_reg && !s3Last_reg;
    assign cpuRstRelease = cpuRstSync_reg && !cpuRstLast_reg;
    assign linkFall = clkLast_reg && !clkSync_reg;
    assign linkRise = !clkLast_reg && clkSync_reg;

    // System power state
    lam_pwr_t pwr_next;
    logic prebootEntry;

    always_comb begin
        pwr_next = powerState;
        unique case (powerState)
            LAM_PWR_PREBOOT: begin
                if (powerButtonOverride) begin
                    pwr_next = LAM_PWR_G2;
                end else if (cpuRstRelease) begin
                    pwr_next = LAM_PWR_G0;
                end
            end
            LAM_PWR_G0: begin
                if (powerButtonOverride) begin
                    pwr_next = LAM_PWR_G2;
                end else if (sleepEnable && sleepType == SLP_TYPE_S5) begin
                    pwr_next = LAM_PWR_G2;
                end else if (sleepEnable && sleepType inside {[SLP_TYPE_S1:SLP_TYPE_S4]}) begin
                    pwr_next = LAM_PWR_G1;
                end
            end
            LAM_PWR_G1: begin
                if (powerButtonOverride) begin
                    pwr_next = LAM_PWR_G2;
                end else if (s3Deassert) begin
                    pwr_next = LAM_PWR_PREBOOT;
                end
            end
            LAM_PWR_G2: begin
                if (s3Deassert) begin
                    pwr_next = LAM_PWR_PREBOOT;
                end
            end
        endcase
    end

    assign prebootEntry = pwr_next == LAM_PWR_PREBOOT && powerState != LAM_PWR_PREBOOT;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerState <= PWR_RESET;
        end else begin
            powerState <= pwr_next;
        end
    end

    // Reboot attempt and processor-missing tracking
    logic dtoLast_reg;
    logic rebootAttempted_reg;
    logic procMissingLatch_reg;
    logic procMissing;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dtoLast_reg <= 1'b0;
            rebootRequest <= 1'b0;
        end else begin
            dtoLast_reg <= doubleTimeoutFlag;
            rebootRequest <= !rebootInhibit && doubleTimeoutFlag && !dtoLast_reg;
        end
    end

    // The attempt mark lives in the standby domain so it outlasts the system reboot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rebootAttempted_reg <= 1'b0;
            procMissingLatch_reg <= 1'b0;
        end else begin
            if (rebootRequest) begin
                rebootAttempted_reg <= 1'b1;
            end else if (!doubleTimeoutFlag) begin
                rebootAttempted_reg <= 1'b0;
            end
            if (&{rebootAttempted_reg, doubleTimeoutFlag, bootFailFlag, mgmtWatchdogExpire}) begin
                procMissingLatch_reg <= 1'b1;
            end else if (!doubleTimeoutFlag) begin
                procMissingLatch_reg <= 1'b0;
            end
        end
    end

    assign procMissing = (rebootInhibit && doubleTimeoutFlag && bootFailFlag)
        || procMissingLatch_reg;

    // Sticky event bits, cleared when a message samples them; a new event wins over the clear
    logic timerSticky_reg;
    logic softwareSticky_reg;
    logic msgStart;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timerSticky_reg <= 1'b0;
            softwareSticky_reg <= 1'b0;
        end else begin
            if (mgmtWatchdogExpire) begin
                timerSticky_reg <= 1'b1;
            end else if (msgStart) begin
                timerSticky_reg <= 1'b0;
            end
            if (sendImmediately) begin
                softwareSticky_reg <= 1'b1;
            end else if (msgStart) begin
                softwareSticky_reg <= 1'b0;
            end
        end
    end

    // Event detection
    logic intrLast_reg, tempLast_reg, procLast_reg;
    logic eventHit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intrLast_reg <= 1'b0;
            tempLast_reg <= 1'b0;
            procLast_reg <= 1'b0;
        end else begin
            intrLast_reg <= intrusionLatched;
            tempLast_reg <= !overtempSync_reg;
            procLast_reg <= procMissing;
        end
    end

    assign eventHit = (intrusionLatched && !intrLast_reg)
        || (!overtempSync_reg && !tempLast_reg)
        || (procMissing && !procLast_reg)
        || mgmtWatchdogExpire
        || sendImmediately
        || gpioToggle
        || prebootEntry;

    // Heartbeat interval
    logic hbTick;

    lam_heartbeat #(
        .INTERVAL(HEARTBEAT_INTERVAL)
    ) u_heartbeat (
        .clk(clk),
        .rst_n(rst_n),
        .tick(hbTick)
    );

    // Pending requests; an event that lands while a message is out is sent after it
    logic eventPending_reg;
    logic hbPending_reg;
    logic serBusy;
    logic sendEvent;

    assign msgStart = !serBusy && !msgBusy && (eventPending_reg || hbPending_reg);
    assign sendEvent = eventPending_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eventPending_reg <= 1'b0;
            hbPending_reg <= 1'b0;
        end else begin
            if (eventHit) begin
                eventPending_reg <= 1'b1;
            end else if (msgStart && sendEvent) begin
                eventPending_reg <= 1'b0;
            end
            if (hbTick) begin
                hbPending_reg <= 1'b1;
            end else if (msgStart) begin
                hbPending_reg <= 1'b0;
            end
        end
    end

    // Sequence number advances only for event messages and wraps naturally
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msgSequence <= SEQ_RESET;
        end else if (msgStart && sendEvent) begin
            msgSequence <= msgSequence + 4'h1;
        end
    end

    // Message snapshot, taken once so the fields hold still for the whole shift
    lam_msg_t frame_reg;
    logic startSer_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg <= '0;
            startSer_reg <= 1'b0;
        end else begin
            startSer_reg <= msgStart;
            if (msgStart) begin
                frame_reg.coverTamper <= intrusionLatched;
                frame_reg.tempEvent <= !overtempSync_reg;
                frame_reg.procMissing <= procMissing;
                frame_reg.timerEvent <= timerSticky_reg || mgmtWatchdogExpire;
                frame_reg.softwareEvent <= softwareSticky_reg || sendImmediately;
                frame_reg.gpioStatus <= !gpioSync_reg;
                frame_reg.msgSequence <= sendEvent ? msgSequence + 4'h1 : msgSequence;
                frame_reg.powerState <= powerState;
                frame_reg.userMessageA <= userMessageA;
                frame_reg.userMessageB <= userMessageB;
                frame_reg.watchdogStatusByte <= watchdogStatusByte;
            end
        end
    end

    // Busy covers the cycle between snapshot and serializer start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msgBusy <= 1'b0;
        end else begin
            msgBusy <= msgStart || startSer_reg || serBusy;
        end
    end

    logic serOe, serAck, serNack;

    lam_serializer u_serializer (
        .clk(clk),
        .rst_n(rst_n),
        .start(startSer_reg),
        .frame(frame_reg),
        .linkFall(linkFall),
        .linkRise(linkRise),
        .dataLevel(dataSync_reg),
        .busy(serBusy),
        .dataOe(serOe),
        .ackPulse(serAck),
        .nackPulse(serNack)
    );

    // Open-drain data pin: only ever pulls low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alertDataOut <= 1'b0;
            alertDataOe <= 1'b0;
            msgAcked <= 1'b0;
            msgNacked <= 1'b0;
        end else begin
            alertDataOut <= 1'b0;
            alertDataOe <= serOe;
            msgAcked <= serAck;
            msgNacked <= serNack;
        end
    end
endmodule // lan_alert_message_builder
`default_nettype wire

// ==== verif/lam_ctrl_model.sv ====
// Network controller model: clocks each frame, captures its bits, answers the ack slot
`timescale 1ns/1ps
`default_nettype none
module lam_ctrl_model (
    input wire logic run,
    input wire logic ackEn,
    input wire logic dataLevel,
    output logic linkClk,
    output logic ackOe,
    output logic [35:0] rxFrame,
    output logic rxDone
);
    initial begin
        linkClk = 1'b1;
        ackOe = 1'b0;
        rxFrame = '0;
        rxDone = 1'b0;
        forever begin
            wait (run);
            // Clock stands high between frames
            for (int i = 0; i < 37; i++) begin
                #62.5 linkClk = 1'b0;
                if (i == 36) ackOe = ackEn;
                #62.5 linkClk = 1'b1;
                if (i < 36) rxFrame = {rxFrame[34:0], dataLevel};
            end
            wait (!run);
            ackOe = 1'b0;
            rxDone = 1'b1;
            #4 rxDone = 1'b0;
        end
    end
endmodule // lam_ctrl_model
`default_nettype wire

// ==== verif/lan_alert_message_builder_chk.sv ====
// Concurrent checks on the ports of the alert message builder
`timescale 1ns/1ps
`default_nettype none
module lan_alert_message_builder_chk
    import lam_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rebootInhibit,
    input wire logic doubleTimeoutFlag,
    input wire logic sendImmediately,
    input wire logic watchedGpioLine,
    input wire logic sleepEnable,
    input wire logic [2:0] sleepType,
    input wire logic powerButtonOverride,
    input wire logic alertDataOe,
    input wire logic rebootRequest,
    input wire logic [SEQ_BITS-1:0] msgSequence,
    input wire lam_pwr_t powerState,
    input wire logic msgBusy,
    input wire logic msgAcked,
    input wire logic msgNacked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence startSoon;
        ##[1:4] msgBusy;
    endsequence
    // Pin inputs pass a synchroniser first, so the start comes later
    sequence startLater;
        ##[1:10] msgBusy;
    endsequence
    sequence sleepFromG0;
        sleepEnable && powerState == LAM_PWR_G0 && !powerButtonOverride;
    endsequence
    chk_sw_start: assert property (sendImmediately && !msgBusy |-> startSoon)
        else $error("software request did not start a message");
    chk_gpio_start: assert property ($changed(watchedGpioLine) && !msgBusy |-> startLater)
        else $error("watched line change did not start a message");
    chk_seq_step: assert property ($changed(msgSequence)
        |-> msgSequence == $past(msgSequence) + 4'h1)
        else $error("sequence moved by other than one");
    chk_seq_start: assert property ($changed(msgSequence) |-> $rose(msgBusy))
        else $error("sequence moved outside a message start");
    chk_reboot_req: assert property ($rose(doubleTimeoutFlag) && !rebootInhibit
        |=> rebootRequest)
        else $error("no reboot request after second timeout");
    chk_reboot_cause: assert property (rebootRequest
        |-> $past(doubleTimeoutFlag) && !$past(rebootInhibit))
        else $error("reboot request without its cause");
    chk_ovr_g2: assert property (powerButtonOverride |=> powerState == LAM_PWR_G2)
        else $error("override did not give soft off");
    chk_sleep_g1: assert property (sleepFromG0
        ##0 sleepType inside {[SLP_TYPE_S1:SLP_TYPE_S4]} |=> powerState == LAM_PWR_G1)
        else $error("sleep write did not give sleeping state");
    chk_sleep_g2: assert property (sleepFromG0 ##0 sleepType == SLP_TYPE_S5
        |=> powerState == LAM_PWR_G2)
        else $error("soft off write did not give soft off");
    chk_oe_idle: assert property (!msgBusy |-> !alertDataOe)
        else $error("data line pulled outside a message");
    chk_done_ack: assert property ($fell(msgBusy) |-> ##[0:3] (msgAcked || msgNacked))
        else $error("message ended without acknowledge result");
endmodule // lan_alert_message_builder_chk

bind lan_alert_message_builder lan_alert_message_builder_chk lan_alert_message_builder_chk_inst (
    .clk(clk), .rst_n(rst_n), .rebootInhibit(rebootInhibit),
    .doubleTimeoutFlag(doubleTimeoutFlag), .sendImmediately(sendImmediately),
    .watchedGpioLine(watchedGpioLine), .sleepEnable(sleepEnable), .sleepType(sleepType),
    .powerButtonOverride(powerButtonOverride), .alertDataOe(alertDataOe),
    .rebootRequest(rebootRequest), .msgSequence(msgSequence), .powerState(powerState),
    .msgBusy(msgBusy), .msgAcked(msgAcked), .msgNacked(msgNacked)
);
`default_nettype wire

// ==== verif/tb_lan_alert_message_builder.sv ====
// Self-checking bench for the alert message builder
`timescale 1ns/1ps
`default_nettype none
module tb_lan_alert_message_builder;
    import lam_pkg::*;
    // Short heartbeat so that two of them fit in the run
    localparam logic [31:0] HB = 32'h0000_3E80;
    logic clk = 1'b0, rst_n = 1'b0, intr = 1'b0, otN = 1'b1, inhibit = 1'b0, dbl = 1'b0;
    logic bootFail = 1'b0, wdExp = 1'b0, sendNow = 1'b0, gpio = 1'b1, s3N = 1'b0, cpuN = 1'b0;
    logic slpEn = 1'b0, ovr = 1'b0, ackEn = 1'b1, gotAck = 1'b0, gotNack = 1'b0;
    logic linkClk, ackOe, dOut, dOe, reboot, busy, acked, nacked, rxDone;
    logic [2:0] slpTyp = 3'h0;
    logic [7:0] msgA = 8'h00, msgB = 8'h00, wdByte = 8'h00;
    logic [3:0] seq, expSeq = 4'h0;
    logic [35:0] rxFrame;
    lam_pwr_t pwr, expPwr = LAM_PWR_G2;
    logic [31:0] rnd = 32'hB018AB55;
    int mismatches = 0, samplesChecked = 0, cycles = 0;
    // Pulled-up line: low whenever either side pulls
    wire logic dataLevel = !(dOe || ackOe);
    logic [11:0] steps [23] = '{12'h311, 12'h021, 12'h036, 12'h134, 12'h240, 12'h220,
        12'h210, 12'h311, 12'h240, 12'h210, 12'h311, 12'h021, 12'h131, 12'h110, 12'h311,
        12'h320, 12'h021, 12'h235, 12'h210, 12'h311, 12'h320, 12'h021, 12'h240};

    lan_alert_message_builder #(.HEARTBEAT_INTERVAL(HB)) lan_alert_message_builder_inst (
        .clk(clk), .rst_n(rst_n), .intrusionLatched(intr), .overtempInputN(otN),
        .rebootInhibit(inhibit), .doubleTimeoutFlag(dbl), .bootFailFlag(bootFail),
        .mgmtWatchdogExpire(wdExp), .sendImmediately(sendNow), .watchedGpioLine(gpio),
        .userMessageA(msgA), .userMessageB(msgB), .watchdogStatusByte(wdByte),
        .sleepS3OutN(s3N), .cpuResetN(cpuN), .sleepEnable(slpEn), .sleepType(slpTyp),
        .powerButtonOverride(ovr), .alertClkIn(linkClk), .alertDataIn(dataLevel),
        .alertDataOut(dOut), .alertDataOe(dOe), .rebootRequest(reboot), .msgSequence(seq),
        .powerState(pwr), .msgBusy(busy), .msgAcked(acked), .msgNacked(nacked));
    lam_ctrl_model lam_ctrl_model_inst (.run(busy), .ackEn(ackEn), .dataLevel(dataLevel),
        .linkClk(linkClk), .ackOe(ackOe), .rxFrame(rxFrame), .rxDone(rxDone));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (acked) gotAck <= 1'b1;
        if (nacked) gotNack <= 1'b1;
        if (cycles == 80000) begin
            mismatches++;
            finalReport();
        end
    end

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    function automatic lam_msg_t expMsg(input logic sw, input logic tm, input logic proc);
        return {intr, !otN, proc, tm, sw, !gpio, expSeq, expPwr, msgA, msgB, wdByte};
    endfunction
    task automatic cmpFrame(input lam_msg_t got, input lam_msg_t exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected frame at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpBits(input logic [3:0] got, input logic [3:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Heartbeats carry the old sequence, so up to three frames not matching are skipped
    task automatic getFrame(input logic sw, input logic tm, input logic proc);
        lam_msg_t r;
        int n = 0;
        do begin
            gotAck = 1'b0;
            gotNack = 1'b0;
            @(posedge rxDone);
            r = rxFrame;
            n++;
        end while (r.msgSequence !== expSeq && n < 4);
        cmpFrame(r, expMsg(sw, tm, proc));
        repeat (8) @(negedge clk);
        cmpBits({1'b0, dOut, gotAck, gotNack}, {2'b00, ackEn, !ackEn});
    endtask
    task automatic endTest(input string name);
        $display("test %s done", name);
    endtask
    task automatic finalReport();
        $display("checked %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin : mainSeq
        int k;
        logic sw;
        logic [11:0] s;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmpBits(seq, 4'h0);
        cmpBits({2'b00, pwr}, 4'h2);
        endTest("reset");
        for (int i = 0; i < 20; i++) begin
            k = int'(xs() % 32'd5);
            ackEn = (i != 7);
            @(posedge clk);
            msgA <= 8'(xs());
            msgB <= 8'(xs());
            wdByte <= 8'(xs());
            case (k)
                1: gpio <= !gpio;
                2: otN <= !otN;
                3: intr <= !intr;
                4: wdExp <= 1'b1;
                default: ;
            endcase
            @(posedge clk);
            wdExp <= 1'b0;
            // Changes that raise no event of their own are followed by a software request
            sw = (k == 0) || (k == 2 && otN) || (k == 3 && !intr);
            if (sw) begin
                repeat (6) @(posedge clk);
                @(posedge clk) sendNow <= 1'b1;
                @(posedge clk) sendNow <= 1'b0;
            end
            expSeq = expSeq + 4'h1;
            getFrame(sw, k == 4, 1'b0);
        end
        ackEn = 1'b1;
        endTest("events");
        @(posedge clk);
        inhibit <= 1'b1;
        dbl <= 1'b1;
        bootFail <= 1'b1;
        expSeq = expSeq + 4'h1;
        getFrame(1'b0, 1'b0, 1'b1);
        @(posedge clk);
        inhibit <= 1'b0;
        dbl <= 1'b0;
        bootFail <= 1'b0;
        repeat (4) @(posedge clk);
        dbl <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        cmpBits({3'h0, reboot}, 4'h1);
        @(posedge clk);
        bootFail <= 1'b1;
        repeat (3) @(posedge clk);
        @(posedge clk) wdExp <= 1'b1;
        @(posedge clk) wdExp <= 1'b0;
        expSeq = expSeq + 4'h1;
        getFrame(1'b0, 1'b1, 1'b1);
        if (busy) begin
            expSeq = expSeq + 4'h1;
            getFrame(1'b0, 1'b0, 1'b1);
        end
        @(posedge clk);
        dbl <= 1'b0;
        bootFail <= 1'b0;
        endTest("reboot");
        for (int i = 0; i < 23; i++) begin
            s = steps[i];
            @(posedge clk);
            case (s[7:4])
                4'h1: s3N <= s[0];
                4'h2: cpuN <= s[0];
                4'h3: begin
                    slpEn <= 1'b1;
                    slpTyp <= s[2:0];
                end
                default: ovr <= 1'b1;
            endcase
            @(posedge clk);
            slpEn <= 1'b0;
            ovr <= 1'b0;
            expPwr = lam_pwr_t'(s[9:8]);
            repeat (6) @(posedge clk);
            @(negedge clk);
            cmpBits({2'b00, pwr}, {2'b00, s[9:8]});
            if (s[7:0] == 8'h11) begin
                expSeq = expSeq + 4'h1;
                getFrame(1'b0, 1'b0, 1'b0);
            end
        end
        endTest("power");
        getFrame(1'b0, 1'b0, 1'b0);
        k = cycles;
        getFrame(1'b0, 1'b0, 1'b0);
        cmpBits({3'h0, (cycles - k) inside {[HB - 8 : HB + 8]}}, 4'h1);
        endTest("heartbeat");
        finalReport();
    end
endmodule // tb_lan_alert_message_builder
`default_nettype wire
